// ==== pkg/pcls_pkg.sv ====
// Constants and types of the passive configuration load sequencer
package pcls_pkg;

   // ==========================================================
   // Clock and timing
   localparam int unsigned CLK_PERIOD_NS = 40;
   localparam int unsigned T_CF2ST0_MAX_NS = 600;
   localparam int unsigned CF2ST0_CYC = T_CF2ST0_MAX_NS / CLK_PERIOD_NS;
   localparam int unsigned T_STATUS_MIN_US = 268;
   localparam int unsigned STATUS_MIN_CYC =
      (T_STATUS_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned T_CF2ST1_MAX_US = 1506;
   localparam int unsigned CF2ST1_CYC =
      T_CF2ST1_MAX_US * 1000 / CLK_PERIOD_NS;
   localparam int unsigned T_CD2UM_MIN_US = 175;
   localparam int unsigned CD2UM_MIN_CYC =
      (T_CD2UM_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned T_CD2UM_MAX_US = 437;
   localparam int unsigned CD2UM_MAX_CYC =
      T_CD2UM_MAX_US * 1000 / CLK_PERIOD_NS;
   localparam int unsigned T_CLK_MAX_PERIOD_NS = 8;
   localparam int unsigned CD2CU_PERIODS = 4;
   localparam int unsigned CD2CU_CYC =
      (CD2CU_PERIODS * T_CLK_MAX_PERIOD_NS + CLK_PERIOD_NS - 1)
      / CLK_PERIOD_NS;
   localparam int unsigned USER_INIT_CLOCKS = 8576;

   // ==========================================================
   // Register map
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_LOAD_LEN = 8'h04;
   localparam logic [7:0] OFS_STATUS = 8'h08;
   localparam logic [7:0] OFS_WORD_COUNT = 8'h0C;
   localparam logic [7:0] OFS_LAST_WORD = 8'h10;
   localparam logic [31:0] LOAD_LEN_RST = 32'h0000_0010;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;

   // ==========================================================
   // Types
   typedef enum logic [1:0]
   {
      PCLS_SERIAL = 2'b00,
      PCLS_X8 = 2'b01,
      PCLS_X16 = 2'b10,
      PCLS_X32 = 2'b11
   } pcls_bus_mode_t;

   typedef enum logic [2:0]
   {
      PCLS_RESET = 3'b000,
      PCLS_RELEASE = 3'b001,
      PCLS_LOAD = 3'b010,
      PCLS_DONE = 3'b011,
      PCLS_UINIT = 3'b100,
      PCLS_USER = 3'b101
   } pcls_phase_t;

   typedef struct packed
   {
      logic uinit_opt;
      logic decompress;
      logic decrypt;
      pcls_bus_mode_t bus_mode;
   } pcls_ctrl_t;

   typedef struct packed
   {
      pcls_phase_t st;
      logic [31:0] timer;
      logic [3:0] phase;
      logic [31:0] shreg;
      logic [4:0] bitcnt;
      logic [31:0] word_count;
      logic [31:0] last_word;
      logic [31:0] ucount;
      logic load_complete;
      logic status_oe;
      logic status_out;
      logic user_mode;
      logic uclk_en;
      logic req_prev;
      logic clk_prev;
      logic uclk_prev;
      pcls_ctrl_t ctrl;
      logic [31:0] load_len;
      logic aw_got;
      logic w_got;
      logic [7:0] awaddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } pcls_state_t;

endpackage

// ==== hw/pcls_sync.sv ====
// Two-flop synchroniser for pins from outside the clock domain
`timescale 1ns/1ps
module pcls_sync
#(
   parameter int unsigned W = 1
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);

   typedef struct packed
   {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } pcls_sync_st_t;

   pcls_sync_st_t r;
   pcls_sync_st_t next_r;

   // ==========================================================
   // Two stages
   always_comb
   begin
      next_r.s1 = din;
      next_r.s2 = r.s1;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         r <= '0;
      else
         r <= next_r;
   end

   assign dout = r.s2;

endmodule

// ==== hw/pcls_top.sv ====
// Passive configuration load sequencer with AXI4-Lite registers
`timescale 1ns/1ps
// Function
// - A fall of the request line drives load_complete low within 600 ns.
// - A fall of the request line pulls the status line low within 600 ns.
// - The status line stays low at least 268 us and until the request rises.
// - The status line is released within 1506 us after the request rises.
// - Each data word is sampled on a rising edge of the load clock.
// - With the internal clock, user mode comes 175 to 437 us after done.
// - The user init clock is enabled no sooner than four periods after done.
// - User mode follows the user clock enable plus 8576 user clocks.
// - Ratio one applies with decryption and decompression both off, in serial mode, and in x8 without decompression.
module pcls_top
#(
   parameter int unsigned STATUS_MIN_CYC = pcls_pkg::STATUS_MIN_CYC,
   parameter int unsigned INIT_MIN_CYC = pcls_pkg::CD2UM_MIN_CYC,
   parameter int unsigned USER_INIT_CYC = pcls_pkg::USER_INIT_CLOCKS
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [7:0] s_axi_araddr,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   input wire logic config_request_n,
   input wire logic cfg_status_line_n_in,
   output logic cfg_status_line_n_out,
   output logic cfg_status_line_n_oe,
   output logic load_complete,
   input wire logic config_clock,
   input wire logic [31:0] config_data,
   input wire logic user_init_clock,
   output logic user_init_clock_en,
   output logic user_mode
);

   localparam int A_CF_MAX = int'(pcls_pkg::CF2ST0_CYC);

   pcls_pkg::pcls_state_t r;
   pcls_pkg::pcls_state_t next_r;
   logic [35:0] sync_out;
   logic req_s;
   logic stat_s;
   logic clk_s;
   logic uclk_s;
   logic [31:0] data_s;
   logic req_fall;
   logic clk_rise;
   logic uclk_rise;
   logic [3:0] ratio;
   logic [31:0] masked_data;

   // ==========================================================
   // Decoding helpers
   function automatic logic [3:0] pcls_ratio(input pcls_pkg::pcls_ctrl_t c);
      logic [3:0] rt;
      rt = 4'h1;
      case (c.bus_mode)
         pcls_pkg::PCLS_X8:
            if (c.decompress)
               rt = 4'h2;
         pcls_pkg::PCLS_X16:
            if (c.decompress)
               rt = 4'h4;
            else if (c.decrypt)
               rt = 4'h2;
         pcls_pkg::PCLS_X32:
            if (c.decompress)
               rt = 4'h8;
            else if (c.decrypt)
               rt = 4'h4;
         default:
            rt = 4'h1;
      endcase
      return rt;
   endfunction

   function automatic logic [31:0] pcls_mask(input pcls_pkg::pcls_bus_mode_t m);
      logic [31:0] mk;
      case (m)
         pcls_pkg::PCLS_X8:
            mk = 32'h0000_00FF;
         pcls_pkg::PCLS_X16:
            mk = 32'h0000_FFFF;
         pcls_pkg::PCLS_X32:
            mk = 32'hFFFF_FFFF;
         default:
            mk = 32'h0000_0001;
      endcase
      return mk;
   endfunction

   function automatic logic [31:0] pcls_merge(input logic [31:0] old,
      input logic [31:0] wd, input logic [3:0] ws);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++)
      begin
         if (ws[i])
            res[8*i +: 8] = wd[8*i +: 8];
      end
      return res;
   endfunction

   // ==========================================================
   // Pin synchronisers
   pcls_sync #(.W(36)) u_sync
   (
      .aclk(aclk),
      .aresetn(aresetn),
      .din({user_init_clock, config_clock, cfg_status_line_n_in,
         config_request_n, config_data}),
      .dout(sync_out)
   );

   assign data_s = sync_out[31:0];
   assign req_s = sync_out[32];
   assign stat_s = sync_out[33];
   assign clk_s = sync_out[34];
   assign uclk_s = sync_out[35];
   assign req_fall = r.req_prev && !req_s;
   assign clk_rise = clk_s && !r.clk_prev;
   assign uclk_rise = uclk_s && !r.uclk_prev;
   assign ratio = pcls_ratio(r.ctrl);
   assign masked_data = data_s & pcls_mask(r.ctrl.bus_mode);

   // ==========================================================
   // Next state
   always_comb
   begin
      logic word_done;
      logic [31:0] wm;
      word_done = 1'b0;
      wm = 32'h0;
      next_r = r;
      next_r.req_prev = req_s;
      next_r.clk_prev = clk_s;
      next_r.uclk_prev = uclk_s;
      // Register writes
      if (s_axi_awvalid && r.awready)
      begin
         next_r.aw_got = 1'b1;
         next_r.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && r.wready)
      begin
         next_r.w_got = 1'b1;
         next_r.wdata = s_axi_wdata;
         next_r.wstrb = s_axi_wstrb;
      end
      if (r.bvalid && s_axi_bready)
         next_r.bvalid = 1'b0;
      if (r.aw_got && r.w_got && !r.bvalid)
      begin
         next_r.aw_got = 1'b0;
         next_r.w_got = 1'b0;
         next_r.bvalid = 1'b1;
         next_r.bresp = pcls_pkg::RESP_OKAY;
         case (r.awaddr)
            pcls_pkg::OFS_CTRL:
            begin
               wm = pcls_merge({27'h0, r.ctrl}, r.wdata, r.wstrb);
               next_r.ctrl = pcls_pkg::pcls_ctrl_t'(wm[4:0]);
            end
            pcls_pkg::OFS_LOAD_LEN:
               next_r.load_len = pcls_merge(r.load_len, r.wdata, r.wstrb);
            pcls_pkg::OFS_STATUS, pcls_pkg::OFS_WORD_COUNT,
            pcls_pkg::OFS_LAST_WORD:
               next_r.bresp = pcls_pkg::RESP_OKAY;
            default:
               next_r.bresp = pcls_pkg::RESP_DECERR;
         endcase
      end
      next_r.awready = !next_r.aw_got && !next_r.bvalid;
      next_r.wready = !next_r.w_got && !next_r.bvalid;
      // Register reads
      if (r.rvalid && s_axi_rready)
         next_r.rvalid = 1'b0;
      if (s_axi_arvalid && r.arready)
      begin
         next_r.rvalid = 1'b1;
         next_r.rresp = pcls_pkg::RESP_OKAY;
         case (s_axi_araddr)
            pcls_pkg::OFS_CTRL:
               next_r.rdata = {27'h0, r.ctrl};
            pcls_pkg::OFS_LOAD_LEN:
               next_r.rdata = r.load_len;
            pcls_pkg::OFS_STATUS:
               next_r.rdata = {20'h0, ratio, 1'b0, r.uclk_en, r.status_oe,
                  r.user_mode, r.load_complete, r.st};
            pcls_pkg::OFS_WORD_COUNT:
               next_r.rdata = r.word_count;
            pcls_pkg::OFS_LAST_WORD:
               next_r.rdata = r.last_word;
            default:
            begin
               next_r.rdata = 32'h0;
               next_r.rresp = pcls_pkg::RESP_DECERR;
            end
         endcase
      end
      next_r.arready = !next_r.rvalid;
      // Sequencer
      case (r.st)
         pcls_pkg::PCLS_RESET:
         begin
            next_r.timer = r.timer + 32'h1;
            if (req_s && r.timer >= 32'(STATUS_MIN_CYC - 1))
            begin
               next_r.st = pcls_pkg::PCLS_RELEASE;
               next_r.status_oe = 1'b0;
            end
         end
         pcls_pkg::PCLS_RELEASE:
         begin
            if (stat_s)
            begin
               next_r.st = pcls_pkg::PCLS_LOAD;
               next_r.phase = 4'h0;
            end
         end
         pcls_pkg::PCLS_LOAD:
         begin
            if (clk_rise)
            begin
               if (r.phase == 4'h0)
               begin
                  if (r.ctrl.bus_mode == pcls_pkg::PCLS_SERIAL)
                  begin
                     next_r.shreg = {data_s[0], r.shreg[31:1]};
                     next_r.bitcnt = r.bitcnt + 5'h01;
                     word_done = (r.bitcnt == 5'h1F);
                     if (word_done)
                        next_r.last_word = next_r.shreg;
                  end
                  else
                  begin
                     next_r.last_word = masked_data;
                     word_done = 1'b1;
                  end
               end
               // Extra clocks per word while decoding
               if (r.phase + 4'h1 >= ratio)
                  next_r.phase = 4'h0;
               else
                  next_r.phase = r.phase + 4'h1;
            end
            if (word_done)
            begin
               next_r.word_count = r.word_count + 32'h1;
               if (next_r.word_count >= r.load_len)
               begin
                  next_r.st = pcls_pkg::PCLS_DONE;
                  next_r.load_complete = 1'b1;
                  next_r.timer = 32'h0;
               end
            end
         end
         pcls_pkg::PCLS_DONE:
         begin
            next_r.timer = r.timer + 32'h1;
            if (r.ctrl.uinit_opt)
            begin
               if (r.timer >= 32'(pcls_pkg::CD2CU_CYC - 1))
               begin
                  next_r.uclk_en = 1'b1;
                  next_r.ucount = 32'h0;
                  next_r.st = pcls_pkg::PCLS_UINIT;
               end
            end
            else if (r.timer >= 32'(INIT_MIN_CYC - 1))
            begin
               next_r.user_mode = 1'b1;
               next_r.st = pcls_pkg::PCLS_USER;
            end
         end
         pcls_pkg::PCLS_UINIT:
         begin
            if (uclk_rise)
            begin
               next_r.ucount = r.ucount + 32'h1;
               if (next_r.ucount >= 32'(USER_INIT_CYC))
               begin
                  next_r.user_mode = 1'b1;
                  next_r.st = pcls_pkg::PCLS_USER;
               end
            end
         end
         pcls_pkg::PCLS_USER:
            next_r.user_mode = 1'b1;
         default:
            next_r.st = pcls_pkg::PCLS_RESET;
      endcase
      // Abort and restart on a new request
      if (req_fall)
      begin
         next_r.st = pcls_pkg::PCLS_RESET;
         next_r.timer = 32'h0;
         next_r.status_oe = 1'b1;
         next_r.load_complete = 1'b0;
         next_r.user_mode = 1'b0;
         next_r.uclk_en = 1'b0;
         next_r.word_count = 32'h0;
         next_r.bitcnt = 5'h00;
         next_r.phase = 4'h0;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         r <= '0;
         r.st <= pcls_pkg::PCLS_RESET;
         r.status_oe <= 1'b1;
         r.load_len <= pcls_pkg::LOAD_LEN_RST;
      end
      else
         r <= next_r;
   end

   // ==========================================================
   // Outputs
   assign s_axi_awready = r.awready;
   assign s_axi_wready = r.wready;
   assign s_axi_bvalid = r.bvalid;
   assign s_axi_bresp = r.bresp;
   assign s_axi_arready = r.arready;
   assign s_axi_rvalid = r.rvalid;
   assign s_axi_rdata = r.rdata;
   assign s_axi_rresp = r.rresp;
   assign cfg_status_line_n_out = r.status_out;
   assign cfg_status_line_n_oe = r.status_oe;
   assign load_complete = r.load_complete;
   assign user_init_clock_en = r.uclk_en;
   assign user_mode = r.user_mode;

   // ==========================================================
   // Checks
   logic [31:0] a_lo_cnt;
   logic [31:0] a_rise_cnt;
   logic [31:0] a_done_cnt;
   logic [31:0] a_ucnt;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         a_lo_cnt <= 32'h0;
         a_rise_cnt <= 32'h0;
         a_done_cnt <= 32'h0;
         a_ucnt <= 32'h0;
      end
      else
      begin
         a_lo_cnt <= r.status_oe ? a_lo_cnt + 32'h1 : 32'h0;
         a_rise_cnt <= (r.status_oe && req_s) ? a_rise_cnt + 32'h1 : 32'h0;
         a_done_cnt <= (r.load_complete && !r.user_mode) ?
            a_done_cnt + 32'h1 : 32'h0;
         a_ucnt <= !r.uclk_en ? 32'h0 :
            a_ucnt + {31'h0, uclk_rise && !r.user_mode};
      end
   end

   default clocking a_cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   a_done_low: assert property (
      $fell(config_request_n) |-> ##[1:A_CF_MAX] !load_complete)
      else $error("load_complete not low after request fall");
   a_status_low: assert property (
      $fell(config_request_n) |-> ##[1:A_CF_MAX] cfg_status_line_n_oe)
      else $error("status line not pulled low after request fall");
   a_status_min: assert property (
      $fell(r.status_oe) |-> $past(a_lo_cnt) >= 32'(STATUS_MIN_CYC - 1))
      else $error("status low pulse too short");
   a_status_release: assert property (
      r.status_oe |-> a_rise_cnt <= 32'(pcls_pkg::CF2ST1_CYC))
      else $error("status line held too long after request rise");
   a_word_sample: assert property (
      (r.st == pcls_pkg::PCLS_LOAD && clk_rise && r.phase == 4'h0
      && r.ctrl.bus_mode != pcls_pkg::PCLS_SERIAL && !req_fall)
      |=> r.last_word == $past(masked_data))
      else $error("word not captured on load clock rise");
   a_init_time: assert property (
      ($rose(r.user_mode) && !r.ctrl.uinit_opt) |->
      (a_done_cnt >= 32'(INIT_MIN_CYC - 1)
      && a_done_cnt <= 32'(pcls_pkg::CD2UM_MAX_CYC)))
      else $error("user mode outside internal init window");
   a_uclk_enable: assert property (
      $rose(r.uclk_en) |-> a_done_cnt >= 32'(pcls_pkg::CD2CU_CYC))
      else $error("user init clock enabled too early");
   a_uclk_count: assert property (
      ($rose(r.user_mode) && r.ctrl.uinit_opt) |->
      a_ucnt >= 32'(USER_INIT_CYC))
      else $error("user mode before enough user clocks");
   a_ratio_one: assert property (
      (!r.ctrl.decrypt && !r.ctrl.decompress) |-> ratio == 4'h1)
      else $error("ratio not one with decoding off");
   a_ratio_phase: assert property (
      (r.ctrl.bus_mode == pcls_pkg::PCLS_X32 && r.ctrl.decompress
      && r.st == pcls_pkg::PCLS_LOAD) |-> ratio == 4'h8 && r.phase < ratio)
      else $error("word phase outside ratio");
   a_abort_restart: assert property (
      req_fall |=> r.st == pcls_pkg::PCLS_RESET && !r.load_complete
      && r.status_oe)
      else $error("request fall did not restart the sequence");

   c_user_internal: cover property ($rose(r.user_mode) && !r.ctrl.uinit_opt);
   c_user_uclk: cover property ($rose(r.user_mode) && r.ctrl.uinit_opt);
   c_abort_load: cover property (r.st == pcls_pkg::PCLS_LOAD && req_fall);
   c_load_done: cover property ($rose(r.load_complete));

endmodule

// ==== bench/pcls_host_model.sv ====
// Model of the external host that loads the configuration
`timescale 1ns/1ps
module pcls_host_model
(
   input wire logic status_oe,
   input wire logic status_out,
   output logic status_line_n,
   output logic config_request_n,
   output logic config_clock,
   output logic [31:0] config_data,
   output logic user_init_clock
);
   logic hold_low = 1'b0;

   // ==========================================================
   // Open-drain status line with pull-up
   assign status_line_n = !((status_oe && !status_out) || hold_low);

   initial
   begin
      config_request_n = 1'b1;
      config_clock = 1'b0;
      config_data = 32'h0;
      user_init_clock = 1'b0;
   end

   // ==========================================================
   // Request pulse
   task automatic pulse_request;
      #10;
      config_request_n = 1'b0;
      #2000;
      config_request_n = 1'b1;
   endtask

   // Wait for status high before first clock
   task automatic wait_ready;
      wait (status_line_n === 1'b1);
      #2010;
   endtask

   // One word, ratio clocks of 320 ns each per word, or per bit when serial
   task automatic send_word(input logic [31:0] w, input int ratio,
      input bit serial);
      for (int b = 0; b < (serial ? 32 : 1); b++)
      begin
         config_data = serial ? {32{w[b]}} : w;
         #80;
         repeat (ratio)
         begin
            config_clock = 1'b1;
            #160;
            config_clock = 1'b0;
            #160;
         end
      end
      config_data = ~config_data;
   endtask

   // User init clock pulses
   task automatic user_clocks(input int n);
      #10;
      repeat (n)
      begin
         user_init_clock = 1'b1;
         #100;
         user_init_clock = 1'b0;
         #100;
      end
   endtask
endmodule

// ==== bench/test_pcls_top.sv ====
// Testbench of the passive configuration load sequencer
`timescale 1ns/1ps
module test_pcls_top;
   localparam int SMIN = 80;
   localparam int IMIN = 30;
   localparam int UCYC = 10;
   logic aclk;
   logic aresetn = 1'b0;
   logic s_axi_awvalid = 1'b0;
   logic s_axi_wvalid = 1'b0;
   logic s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0;
   logic s_axi_rready = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00;
   logic [7:0] s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, config_request_n, st_in, st_out, st_oe;
   logic load_complete, config_clock, user_init_clock;
   logic user_init_clock_en, user_mode;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp;
   logic [31:0] s_axi_rdata, config_data, rd;
   int fail_count = 0;
   int compares = 0;
   int cyc = 0;
   int cd_cyc = 0;
   int um_cyc = 0;
   logic [7:0] ctl [8] = '{8'h0C, 8'h05, 8'h09, 8'h06, 8'h0A, 8'h07,
      8'h1B, 8'h12};
   int rat [8] = '{1, 1, 2, 2, 4, 4, 8, 1};

   pcls_top #(.STATUS_MIN_CYC(SMIN), .INIT_MIN_CYC(IMIN),
      .USER_INIT_CYC(UCYC)) DUT
   (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .config_request_n(config_request_n), .cfg_status_line_n_in(st_in),
      .cfg_status_line_n_out(st_out), .cfg_status_line_n_oe(st_oe),
      .load_complete(load_complete), .config_clock(config_clock),
      .config_data(config_data), .user_init_clock(user_init_clock),
      .user_init_clock_en(user_init_clock_en), .user_mode(user_mode)
   );

   pcls_host_model host
   (
      .status_oe(st_oe), .status_out(st_out), .status_line_n(st_in),
      .config_request_n(config_request_n), .config_clock(config_clock),
      .config_data(config_data), .user_init_clock(user_init_clock)
   );

   // ==========================================================
   // Clock and timeout
   initial
   begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end

   always @(posedge aclk)
   begin
      cyc++;
      if (load_complete !== 1'b1)
         cd_cyc = cyc;
      if (user_mode !== 1'b1)
         um_cyc = cyc;
      if (cyc == 40000)
      begin
         fail_count++;
         test_done();
      end
   end

   // ==========================================================
   // Shared tasks
   task automatic test_done;
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] seen,
      input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic axw(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wready)
            s_axi_wvalid <= 1'b0;
      end
      while (!s_axi_bvalid);
      resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask

   task automatic axr(input logic [7:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (s_axi_arready)
            s_axi_arvalid <= 1'b0;
      end
      while (!s_axi_rvalid);
      rd = s_axi_rdata;
      resp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask

   // ==========================================================
   // Scenarios
   task automatic t_regs;
      chk("status_oe", {31'h0, st_oe}, 32'h1);
      chk("status_out", {31'h0, st_out}, 32'h0);
      axr(pcls_pkg::OFS_LOAD_LEN);
      chk("load_len", rd, pcls_pkg::LOAD_LEN_RST);
      axr(8'h40);
      chk("rresp", {30'h0, resp}, {30'h0, pcls_pkg::RESP_DECERR});
      chk("rdata", rd, 32'h0);
      axw(pcls_pkg::OFS_WORD_COUNT, 32'hFFFF_FFFF);
      chk("bresp", {30'h0, resp}, {30'h0, pcls_pkg::RESP_OKAY});
      axr(pcls_pkg::OFS_WORD_COUNT);
      chk("word_count_ro", rd, 32'h0);
   endtask

   task automatic t_mode(input int i);
      int c;
      int t_on;
      int t_off;
      logic [31:0] w;
      logic [31:0] m;
      w = 32'hA5C3_0F11 + 32'(i);
      m = ctl[i][1:0] == 2'h1 ? 32'hFF : ctl[i][1:0] == 2'h2 ? 32'hFFFF : '1;
      axw(pcls_pkg::OFS_CTRL, {24'h0, ctl[i]});
      axw(pcls_pkg::OFS_LOAD_LEN, 32'h2);
      host.hold_low = 1'b1;
      t_on = 999;
      t_off = 999;
      c = 0;
      fork
         host.pulse_request();
         while (c < 400 && t_off == 999)
         begin
            @(posedge aclk);
            c++;
            if (t_on == 999 && st_oe === 1'b1 && load_complete === 1'b0)
               t_on = c;
            if (t_on != 999 && st_oe === 1'b0)
               t_off = c;
         end
      join
      chk("request_to_low", 32'(t_on <= 15), 32'h1);
      chk("low_width", 32'(t_off - t_on >= SMIN), 32'h1);
      chk("release_time", 32'(t_off <= SMIN + 70), 32'h1);
      axr(pcls_pkg::OFS_STATUS);
      chk("held_phase", {29'h0, rd[2:0]}, 32'h1);
      host.hold_low = 1'b0;
      host.wait_ready();
      host.send_word(~w, rat[i], i == 0);
      host.send_word(w, rat[i], i == 0);
      c = 0;
      while (load_complete !== 1'b1 && c < 60)
      begin
         @(posedge aclk);
         c++;
      end
      chk("load_complete", {31'h0, load_complete}, 32'h1);
      c = 0;
      if (ctl[i][4])
      begin
         @(posedge aclk);
         chk("uclk_en", {31'h0, user_init_clock_en}, 32'h1);
         host.user_clocks(UCYC - 1);
         chk("early_user", {31'h0, user_mode}, 32'h0);
         host.user_clocks(1);
      end
      while (user_mode !== 1'b1 && c < 200)
      begin
         @(posedge aclk);
         c++;
      end
      if (ctl[i][4])
         chk("user_mode", 32'(c <= 8), 32'h1);
      else
         chk("init_time", 32'(um_cyc - cd_cyc >= IMIN
            && um_cyc - cd_cyc <= IMIN + 8), 32'h1);
      axr(pcls_pkg::OFS_WORD_COUNT);
      chk("word_count", rd, 32'h2);
      axr(pcls_pkg::OFS_LAST_WORD);
      chk("last_word", rd, w & m);
      axr(pcls_pkg::OFS_STATUS);
      chk("ratio", {28'h0, rd[11:8]}, 32'(rat[i]));
   endtask

   initial
   begin
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      t_regs();
      for (int i = 0; i < 8; i++)
         t_mode(i);
      test_done();
   end
endmodule
